// >>> battery_cycle_scheduler.sv
// battery cycle scheduler, blink, inhibit and overcurrent flags of a dc ups
//
// Functional notes
// - blink output during backup with on/off times
// - enabled cycling runs periodic scheduled discharge
// - repeat interval held in weeks
// - recompute schedule on parameter change, startup
// - next event at earliest matching weekday/time
// - on match start, schedule N weeks later
// - end on soc or time threshold
// - skip scheduled start while charging
// - abort immediately on input undervoltage
// - clearing enable stops running discharge
// - stop command ends running discharge
// - manual start ignores battery, keeps schedule
// - in-progress indication while discharging
// - next scheduled time readable
// - log start voltage, end minimum voltage
// - log trigger: schedule 1, user 2
// - log end reason codes 1 to 5
// - inhibit blocks backup or output off
// - selectable inhibit polarity
// - separate input/output/battery overcurrent flags
`timescale 1ns/1ps
module battery_cycle_scheduler
    import cycle_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic [2:0]  rtc_day_i,
    input  wire logic [4:0]  rtc_hour_i,
    input  wire logic [5:0]  rtc_min_i,
    input  wire logic        backup_i,
    input  wire logic        charging_i,
    input  wire logic        input_uv_i,
    input  wire logic [6:0]  soc_i,
    input  wire logic [15:0] bat_mv_i,
    input  wire logic        inhibit_i,
    input  wire logic [9:0]  in_cur_i,
    input  wire logic [9:0]  out_cur_i,
    input  wire logic [9:0]  bat_cur_i,
    output logic             out_en_o,
    output logic             backup_allow_o,
    output logic             discharge_o,
    output logic             cycle_active_o,
    output logic [2:0]       ocp_o,
    output logic             log_valid_o
);
    typedef struct packed {
        cyc_state_t  st;
        logic        run;
        // settings
        logic [3:0]  ctrl;
        logic [7:0]  every;
        logic [2:0]  day;
        logic [4:0]  hour;
        logic [5:0]  min;
        logic [6:0]  soc_th;
        logic [15:0] time_th;
        logic [15:0] t_on;
        logic [15:0] t_off;
        logic [9:0]  lim_in;
        logic [9:0]  lim_out;
        logic [9:0]  lim_bat;
        // schedule
        logic [7:0]  wk_left;
        logic        recalc;
        logic        started_up;
        logic [5:0]  last_min;
        // run and log
        logic [15:0] run_min;
        logic [15:0] vmin;
        logic [2:0]  log_act;
        logic [15:0] log_val;
        logic [2:0]  log_trig;
        logic [2:0]  log_end;
        logic        log_pulse;
        // bus
        logic [31:0] rdata;
        // blink and pins
        logic [22:0] tick_cnt;
        logic [15:0] blink_cnt;
        logic        blink_ph;
        logic        out_en;
        logic        bk_allow;
        logic [2:0]  ocp;
    } state_t;

    state_t q, d;

    function automatic logic over_lim(input logic [9:0] cur, input logic [9:0] lim);
        over_lim = cur > lim;
    endfunction : over_lim

    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction : min16

    logic       inh_active;
    logic       min_edge;
    logic       time_eq;
    logic       sched_hit;

    logic       cmd_wr;
    logic       start_cmd;
    logic       stop_cmd;
    logic       en_drop;
    logic       blink_gate;
    logic       stop_req;
    logic [2:0] stop_code;

    always_comb begin
        d = q;
        d.log_pulse = 1'b0;
        // polarity folded in once so every user sees the active level
        inh_active = inhibit_i ^ q.ctrl[CTRL_INH_POL];
        // a minute change is the only strobe, so one match starts one run
        min_edge = rtc_min_i != q.last_min;
        time_eq = rtc_day_i == q.day && rtc_hour_i == q.hour && rtc_min_i == q.min;
        // no hit before startup has re-armed the schedule
        sched_hit = min_edge && time_eq && q.ctrl[CTRL_CYC_EN] && q.started_up && !q.recalc;
        // command and setting decode shared by the state machine
        cmd_wr = wr_i && addr_i == REG_CMD;
        start_cmd = cmd_wr && wdata_i[CMD_START];
        stop_cmd = cmd_wr && wdata_i[CMD_STOP];
        en_drop = wr_i && addr_i == REG_CTRL && !wdata_i[CTRL_CYC_EN] && q.ctrl[CTRL_CYC_EN];
        d.last_min = rtc_min_i;
        stop_req = 1'b0;
        stop_code = END_USER;

        // register write port
        if (wr_i) begin
            unique case (addr_i)
                REG_CTRL: begin
                    d.ctrl = wdata_i[3:0];
                    d.recalc = 1'b1;
                end
                REG_SCHED: begin
                    d.every = (wdata_i[7:0] == 8'h00) ? EVERY_RST : wdata_i[7:0];
                    d.day = (wdata_i[10:8] >= 3'(DAYS_PER_WEEK)) ? DAY_RST : wdata_i[10:8];
                    d.hour = wdata_i[15:11];
                    d.min = wdata_i[21:16];
                    d.recalc = 1'b1;
                end
                REG_THRESH: begin
                    d.soc_th = wdata_i[6:0];
                    d.time_th = wdata_i[31:16];
                    d.recalc = 1'b1;
                end
                REG_BLINK: begin
                    d.t_on = wdata_i[15:0];
                    d.t_off = wdata_i[31:16];
                end
                REG_LIMITS: begin
                    d.lim_in = wdata_i[9:0];
                    d.lim_out = wdata_i[19:10];
                    d.lim_bat = wdata_i[29:20];
                end
                REG_CMD: begin
                    // commands act in the state machine and are not stored
                end
                default: ;
            endcase
        end

        // startup counts as a parameter change
        if (!q.started_up) begin
            d.started_up = 1'b1;
            d.recalc = 1'b1;
        end
        // next match of day/hour/minute is the earliest one: arm with zero weeks left
        if (q.recalc) begin
            d.recalc = 1'b0;
            d.wk_left = 8'h00;
        end

        // weekly countdown: wk_left counts remaining matches to skip
        if (sched_hit && q.wk_left != 8'h00) begin
            d.wk_left = q.wk_left - 8'h01;
        end

        unique case (q.st)
            ST_IDLE: begin
                if (start_cmd) begin
                    d.st = ST_RUN;
                    d.log_trig = TRIG_USER;
                    d.run_min = 16'h0000;
                    d.vmin = bat_mv_i;
                    d.log_act = LOG_STARTED;
                    d.log_val = bat_mv_i;
                    d.log_pulse = 1'b1;
                end else if (sched_hit && q.wk_left == 8'h00) begin
                    d.wk_left = q.every - 8'h01;
                    if (charging_i) begin
                        d.log_end = END_CHARGE;
                        d.log_pulse = 1'b1;
                    end else begin
                        d.st = ST_RUN;
                        d.log_trig = TRIG_SCHED;
                        d.run_min = 16'h0000;
                        d.vmin = bat_mv_i;
                        d.log_act = LOG_STARTED;
                        d.log_val = bat_mv_i;
                        d.log_pulse = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                d.vmin = min16(bat_mv_i, q.vmin);
                if (min_edge) begin
                    d.run_min = q.run_min + 16'h0001;
                end
                // a scheduled hit during a run still advances the schedule
                if (sched_hit && q.wk_left == 8'h00) begin
                    d.wk_left = q.every - 8'h01;
                end
                // priority: undervoltage, user, soc, time
                if (input_uv_i) begin
                    stop_req = 1'b1;
                    stop_code = END_UV;
                end else if (stop_cmd) begin
                    stop_req = 1'b1;
                    stop_code = END_USER;
                end else if (en_drop) begin
                    stop_req = 1'b1;
                    stop_code = END_USER;
                end else if (soc_i <= q.soc_th) begin
                    stop_req = 1'b1;
                    stop_code = END_SOC;
                end else if (q.run_min >= q.time_th) begin
                    stop_req = 1'b1;
                    stop_code = END_TIME;
                end
                if (stop_req) begin
                    d.st = ST_IDLE;
                    d.log_act = LOG_ENDED;
                    d.log_val = min16(bat_mv_i, q.vmin);
                    d.log_end = stop_code;
                    d.log_pulse = 1'b1;
                end
            end
        endcase

        // outputs must come from flops, so the state decode is registered
        d.run = d.st == ST_RUN;

        // blink timebase; trades resolution for a small counter
        if (q.tick_cnt == 23'(BLINK_TICK_CYC - 1)) begin
            d.tick_cnt = 23'h000000;
            if (q.blink_cnt + 16'h0001 >= (q.blink_ph ? q.t_on : q.t_off)) begin
                d.blink_cnt = 16'h0000;
                d.blink_ph = !q.blink_ph;
            end else begin
                d.blink_cnt = q.blink_cnt + 16'h0001;
            end
        end else begin
            d.tick_cnt = q.tick_cnt + 23'h000001;
        end
        if (!(backup_i && q.ctrl[CTRL_BLINK_EN])) begin
            d.blink_ph = 1'b1;
            d.blink_cnt = 16'h0000;
        end

        d.bk_allow = !(inh_active && !q.ctrl[CTRL_DCDC]);
        blink_gate = !backup_i || !q.ctrl[CTRL_BLINK_EN] || d.blink_ph;
        d.out_en = !(inh_active && q.ctrl[CTRL_DCDC]) && blink_gate;
        // flags follow the current every cycle; software polls, nothing latches
        d.ocp[0] = over_lim(in_cur_i, q.lim_in);
        d.ocp[1] = over_lim(out_cur_i, q.lim_out);
        d.ocp[2] = over_lim(bat_cur_i, q.lim_bat);

        // read data stand one cycle only; idle cycles read zero
        d.rdata = 32'h00000000;
        if (rd_i) begin
            unique case (addr_i)
                REG_CTRL: begin
                    d.rdata = {28'h0000000, q.ctrl};
                end
                REG_SCHED: begin
                    d.rdata = {10'h000, q.min, q.hour,
                               q.day, q.every};
                end
                REG_THRESH: begin
                    d.rdata = {q.time_th, 9'h000, q.soc_th};
                end
                REG_BLINK: begin
                    d.rdata = {q.t_off, q.t_on};
                end
                REG_LIMITS: begin
                    d.rdata = {2'h0, q.lim_bat, q.lim_out, q.lim_in};
                end
                REG_CMD: begin
                    d.rdata = 32'h00000000;
                end
                REG_STATUS: begin
                    d.rdata = {q.run_min, 12'h000,
                               q.ocp, q.run};
                end
                REG_NEXT: begin
                    d.rdata = {q.wk_left, 2'h0, q.min,
                               3'h0, q.hour, 5'h00, q.day};
                end
                REG_LOG: begin
                    d.rdata = {q.log_val, 5'h00, q.log_end,
                               1'b0, q.log_trig, 1'b0, q.log_act};
                end
                REG_ID: begin
                    d.rdata = ID_VALUE;
                end
                default: begin
                    d.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // settings wake at defaults; the schedule re-arms on the first edges
            q <= '{
                st:         ST_IDLE,
                run:        1'b0,
                ctrl:       CTRL_RST,
                every:      EVERY_RST,
                day:        DAY_RST,
                hour:       HOUR_RST,
                min:        MIN_RST,
                soc_th:     SOC_TH_RST,
                time_th:    TIME_TH_RST,
                t_on:       BLINK_T_RST,
                t_off:      BLINK_T_RST,
                lim_in:     ILIM_RST,
                lim_out:    ILIM_RST,
                lim_bat:    ILIM_RST,
                wk_left:    8'h00,
                recalc:     1'b0,
                started_up: 1'b0,
                last_min:   6'h00,
                run_min:    16'h0000,
                vmin:       16'h0000,
                log_act:    LOG_ENDED,
                log_val:    16'h0000,
                log_trig:   3'h0,
                log_end:    3'h0,
                log_pulse:  1'b0,
                rdata:      32'h00000000,
                tick_cnt:   23'h000000,
                blink_cnt:  16'h0000,
                blink_ph:   1'b1,
                out_en:     1'b1,
                bk_allow:   1'b1,
                ocp:        3'h0
            };
        end else begin
            q <= d;
        end
    end

    assign rdata_o        = q.rdata;
    assign out_en_o       = q.out_en;
    assign backup_allow_o = q.bk_allow;
    assign discharge_o    = q.run;
    assign cycle_active_o = q.run;
    assign ocp_o          = q.ocp;
    assign log_valid_o    = q.log_pulse;
endmodule : battery_cycle_scheduler

// >>> cycle_pkg.sv
// constants and types shared by the battery cycle scheduler
package cycle_pkg;
    // register index map (byte address = 4 * index)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_SCHED     = 8'h01;
    localparam logic [7:0] REG_THRESH    = 8'h02;
    localparam logic [7:0] REG_BLINK     = 8'h03;
    localparam logic [7:0] REG_LIMITS    = 8'h04;
    localparam logic [7:0] REG_CMD       = 8'h05;
    localparam logic [7:0] REG_STATUS    = 8'h06;
    localparam logic [7:0] REG_NEXT      = 8'h07;
    localparam logic [7:0] REG_LOG       = 8'h08;
    localparam logic [7:0] REG_ID        = 8'h09;
    // control and command bit positions
    localparam int CTRL_CYC_EN   = 0;
    localparam int CTRL_BLINK_EN = 1;
    localparam int CTRL_INH_POL  = 2;
    localparam int CTRL_DCDC     = 3;
    localparam int CMD_START     = 0;
    localparam int CMD_STOP      = 1;
    // reset values
    localparam logic [3:0]  CTRL_RST     = 4'h0;
    localparam logic [7:0]  EVERY_RST    = 8'h01;
    localparam logic [2:0]  DAY_RST      = 3'h0;
    localparam logic [4:0]  HOUR_RST     = 5'h00;
    localparam logic [5:0]  MIN_RST      = 6'h00;
    localparam logic [6:0]  SOC_TH_RST   = 7'h32;
    localparam logic [15:0] TIME_TH_RST  = 16'h003C;
    localparam logic [15:0] BLINK_T_RST  = 16'h0001;
    // current limits in 0.1 A units, 20 A default
    localparam logic [9:0]  ILIM_RST     = 10'h0C8;
    localparam logic [31:0] ID_VALUE     = 32'h00C0FFEE; // arbitrary identity value
    // log codes
    localparam logic [2:0] LOG_ENDED     = 3'h0;
    localparam logic [2:0] LOG_STARTED   = 3'h1;
    localparam logic [2:0] TRIG_SCHED    = 3'h1;
    localparam logic [2:0] TRIG_USER     = 3'h2;
    localparam logic [2:0] END_SOC       = 3'h1;
    localparam logic [2:0] END_TIME      = 3'h2;
    localparam logic [2:0] END_UV        = 3'h3;
    localparam logic [2:0] END_CHARGE    = 3'h4;
    localparam logic [2:0] END_USER      = 3'h5;
    // timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int BLINK_UNIT_MS = 100;
    localparam int BLINK_TICK_CYC = CLK_HZ / 1000 * BLINK_UNIT_MS;
    localparam int DAYS_PER_WEEK = 7;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN} cyc_state_t;
endpackage : cycle_pkg

// >>> battery_cycle_scheduler_props.sv
// port checker for the battery cycle scheduler
`timescale 1ns/1ps
module battery_cycle_scheduler_props
    import cycle_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        input_uv_i,
    input wire logic        inhibit_i,
    input wire logic [9:0]  in_cur_i,
    input wire logic [9:0]  out_cur_i,
    input wire logic [9:0]  bat_cur_i,
    input wire logic        out_en_o,
    input wire logic        backup_allow_o,
    input wire logic        discharge_o,
    input wire logic        cycle_active_o,
    input wire logic [2:0]  ocp_o,
    input wire logic        log_valid_o
);
    logic [3:0]  ctrl_q;
    logic [29:0] lim_q;
    // shadow of the settings, so limits and polarity need no bus reads
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q <= CTRL_RST;
            lim_q  <= {3{ILIM_RST}};
        end else if (wr_i && addr_i == REG_CTRL) begin
            ctrl_q <= wdata_i[3:0];
        end else if (wr_i && addr_i == REG_LIMITS) begin
            lim_q <= wdata_i[29:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_uv; discharge_o && input_uv_i |=> !discharge_o; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage did not abort");
    property p_stop; discharge_o && wr_i && addr_i == REG_CMD && wdata_i[CMD_STOP] |=> !discharge_o; endproperty
    a_stop: assert property (p_stop) else $error("stop command ignored");
    property p_start;
        !discharge_o && wr_i && addr_i == REG_CMD && wdata_i[CMD_START] && !wdata_i[CMD_STOP] && !input_uv_i
            |=> discharge_o && log_valid_o;
    endproperty
    a_start: assert property (p_start) else $error("manual start ignored");
    property p_enclr;
        discharge_o && ctrl_q[CTRL_CYC_EN] && wr_i && addr_i == REG_CTRL && !wdata_i[CTRL_CYC_EN] |=> !discharge_o;
    endproperty
    a_enclr: assert property (p_enclr) else $error("disable did not stop run");
    property p_active; cycle_active_o == discharge_o; endproperty
    a_active: assert property (p_active) else $error("run indication wrong");
    property p_ocp;
        !$past(sys_rst_i) |-> ocp_o == {$past(bat_cur_i) > $past(lim_q[29:20]),
            $past(out_cur_i) > $past(lim_q[19:10]), $past(in_cur_i) > $past(lim_q[9:0])};
    endproperty
    a_ocp: assert property (p_ocp) else $error("overcurrent flags wrong");
    property p_inh_ups;
        !$past(sys_rst_i) && !$past(ctrl_q[CTRL_DCDC]) |-> backup_allow_o == !$past(inhibit_i ^ ctrl_q[CTRL_INH_POL]);
    endproperty
    a_inh_ups: assert property (p_inh_ups) else $error("backup permit wrong");
    property p_inh_dcdc;
        !$past(sys_rst_i) && $past(ctrl_q[CTRL_DCDC]) && $past(inhibit_i ^ ctrl_q[CTRL_INH_POL]) |-> !out_en_o;
    endproperty
    a_inh_dcdc: assert property (p_inh_dcdc) else $error("inhibit left output on");
    property p_log; $changed(discharge_o) |-> log_valid_o; endproperty
    a_log: assert property (p_log) else $error("run edge without log");
    c_start: cover property ($rose(discharge_o));
    c_uv: cover property (discharge_o && input_uv_i);
    c_ocp: cover property (|ocp_o);
endmodule : battery_cycle_scheduler_props

// >>> battery_pack_model.sv
// battery pack and line stand-in driven by the bench
`timescale 1ns/1ps
module battery_pack_model (
    input  wire logic        clk_i,
    input  wire logic [6:0]  soc_set_i,
    input  wire logic        chg_req_i,
    input  wire logic        uv_req_i,
    input  wire logic        discharge_i,
    output logic      [6:0]  soc_o,
    output logic      [15:0] bat_mv_o,
    output logic             charging_o,
    output logic             input_uv_o
);
    // charge settles one cycle after the bench moves it
    always_ff @(posedge clk_i) soc_o <= soc_set_i;
    // voltage follows charge so a dip shows up in the minimum
    assign bat_mv_o   = 16'(12000 + 10 * int'(soc_o));
    // a pack being drained cannot charge at the same time
    assign charging_o = chg_req_i & ~discharge_i;
    assign input_uv_o = uv_req_i;
endmodule : battery_pack_model

// >>> battery_cycle_scheduler_tb.sv
// self-checking bench for the battery cycle scheduler
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module battery_cycle_scheduler_tb
    import cycle_pkg::*;
;
    logic        clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, backup_i = 0, inhibit_i = 0, chg_req = 0, uv_req = 0;
    logic [7:0]  addr_i = '0;
    logic [31:0] wdata_i = '0, rdata_o, d, e;
    logic [2:0]  rtc_day_i = '0, ocp_o, k;
    logic [4:0]  rtc_hour_i = '0;
    logic [5:0]  rtc_min_i = '0;
    logic [9:0]  in_cur_i = '0, out_cur_i = '0, bat_cur_i = '0;
    logic [6:0]  soc_set = 7'h50, soc_i;
    logic [15:0] bat_mv_i;
    logic        charging_i, input_uv_i, out_en_o, backup_allow_o, discharge_o, cycle_active_o, log_valid_o;
    logic [31:0] exp_q[$];
    logic [29:0] lim;
    int          fail_count = 0, cmp_count = 0, cyc = 0, r;
    battery_cycle_scheduler i_battery_cycle_scheduler (.*);
    battery_pack_model i_battery_pack_model (.clk_i(clk_i), .soc_set_i(soc_set), .chg_req_i(chg_req),
        .uv_req_i(uv_req), .discharge_i(discharge_o), .soc_o(soc_i), .bat_mv_o(bat_mv_i),
        .charging_o(charging_i), .input_uv_o(input_uv_i));
    always #10 clk_i = ~clk_i;
    task automatic results();
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task automatic tick(input logic [5:0] m);
        @(posedge clk_i);
        rtc_min_i <= m;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : tick
    // log model: value is the pack voltage for the given charge level
    task automatic lg(input int act, trig, en, soc, input logic [31:0] m);
        exp_q.push_back({16'(12000 + 10 * soc), 5'h00, 3'(en), 1'b0, 3'(trig), 1'b0, 3'(act)});
        rd(REG_LOG);
        e = exp_q.pop_front();
        `CHK(d & m, e & m)
    endtask : lg
    initial begin
        r = $urandom(26238);
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(8'h3F);
        `CHK(d, 32'h0)
        @(posedge clk_i) chg_req <= 1'b1;
        wr(REG_CMD, 32'h1 << CMD_START);
        `CHK(discharge_o, 1'b1)
        lg(1, 2, 0, 80, 32'hFFFF_0077);
        rd(REG_STATUS);
        `CHK(d[0], 1'b1)
        @(posedge clk_i);
        soc_set <= 7'h3C;
        chg_req <= 1'b0;
        repeat (3) @(posedge clk_i);
        soc_set <= 7'h46;
        wr(REG_CMD, 32'h1 << CMD_STOP);
        `CHK(discharge_o, 1'b0)
        lg(0, 0, 5, 60, 32'hFFFF_0707);
        wr(REG_THRESH, 32'h0002_0032);
        wr(REG_SCHED, {10'h000, 6'h07, 5'h05, 3'h3, 8'h02});
        wr(REG_CTRL, 32'h0000_0001);
        @(posedge clk_i);
        {rtc_day_i, rtc_hour_i, rtc_min_i} <= {3'h3, 5'h05, 6'h06};
        soc_set <= 7'h50;
        rd(REG_NEXT);
        `CHK(d, 32'h0007_0503)
        tick(6'h07);
        `CHK(discharge_o, 1'b1)
        lg(1, 1, 0, 80, 32'hFFFF_0077);
        rd(REG_NEXT);
        `CHK(d[31:24], 8'h01)
        @(posedge clk_i);
        soc_set <= 7'h3C;
        repeat (3) @(posedge clk_i);
        soc_set <= 7'h46;
        tick(6'h08);
        tick(6'h09);
        `CHK(discharge_o, 1'b0)
        lg(0, 0, 2, 60, 32'hFFFF_0707);
        // week skip, charging skip, week skip, then a real start
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i) chg_req <= (i == 1);
            tick(6'h08);
            tick(6'h07);
            `CHK(discharge_o, 1'(i == 3))
            if (i == 1) lg(0, 0, 4, 0, 32'h0000_0700);
        end
        @(posedge clk_i) soc_set <= 7'h1E;
        repeat (4) @(posedge clk_i);
        #1;
        `CHK(discharge_o, 1'b0)
        lg(0, 0, 1, 30, 32'h0000_0707);
        @(posedge clk_i) soc_set <= 7'h50;
        for (int i = 0; i < 2; i++) begin
            wr(REG_CTRL, 32'h0000_0001);
            wr(REG_CMD, 32'h1 << CMD_START);
            if (i == 0) wr(REG_CTRL, 32'h0);
            else @(posedge clk_i) uv_req <= 1'b1;
            repeat (3) @(posedge clk_i);
            #1;
            `CHK(discharge_o, 1'b0)
            lg(0, 0, 5 - 2 * i, 80, 32'hFFFF_0707);
            @(posedge clk_i) uv_req <= 1'b0;
        end
        // random currents, limits and inhibit under every polarity and mode
        for (k = 0; k < 4; k++) begin
            wr(REG_CTRL, {28'h0, k[1:0], 2'b00});
            lim = 30'($urandom);
            wr(REG_LIMITS, {2'b00, lim});
            repeat (60) begin
                @(posedge clk_i);
                {in_cur_i, out_cur_i, bat_cur_i} <= 30'($urandom);
                {backup_i, inhibit_i} <= 2'($urandom);
                @(posedge clk_i);
                #1;
                `CHK(ocp_o, {bat_cur_i > lim[29:20], out_cur_i > lim[19:10], in_cur_i > lim[9:0]})
                `CHK(k[1] ? out_en_o : backup_allow_o, ~(inhibit_i ^ k[0]))
            end
            @(posedge clk_i) {backup_i, inhibit_i} <= 2'b00;
            repeat (2) @(posedge clk_i);
            #1;
            `CHK(k[1] ? out_en_o : backup_allow_o, ~k[0])
        end
        results();
    end
endmodule : battery_cycle_scheduler_tb
bind battery_cycle_scheduler battery_cycle_scheduler_props i_battery_cycle_scheduler_props (.*);
